// File: pkg/facd_cfg.svh
`ifndef FACD_CFG_SVH
`define FACD_CFG_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define FACD_ADR_CMD      8'h00
`define FACD_ADR_DATA     8'h04
`define FACD_ADR_STAT     8'h08
`define FACD_ADR_RESULT   8'h0C
`define FACD_ADR_HWSTAT   8'h10
`define FACD_ADR_CTRL     8'h14

// -----------------------------------------------------------------
// Command fields
// -----------------------------------------------------------------
`define FACD_HIGH_FIXED   12'hFF0
`define FACD_PRE_PLAIN    4'h1
`define FACD_PRE_CONV     4'h0
`define FACD_PRE_PRIV     4'h2
`define FACD_PRE_WSTAT    4'h4
`define FACD_PRE_IMM_SRC  4'h9
`define FACD_PRE_IMM_CSRC 4'h8
`define FACD_PRE_IMM_DST  4'h5
`define FACD_OP_LOCK      4'h7
`define FACD_OP_TSW       4'h3
`define FACD_OP_STAT      4'hD
`define FACD_OP_RDREG     4'hF
`define FACD_OP_WRREG     4'h5
`define FACD_OP_MUL       4'hC
`define FACD_OP_NEG       4'h5
`define FACD_OP_SUB       4'h4
`define FACD_OP_FLOOR     4'hE
`define FACD_OP_TRUNC_S   4'hB
`define FACD_OP_TRUNC_L   4'hA
`define FACD_TAIL_STAT    12'hFB8
`define FACD_TAIL_EXC     12'h3C0
`define FACD_REG_STAT     4'hE
`define FACD_REG_EXC      4'hF
`define FACD_EXC_ILLEGAL  4'h7
`define FACD_EXC_PRIV     4'h8
`define FACD_STAT_RO_MASK 32'hFF00_0000
`define FACD_CHECK_MASK   32'h0000_00FF
`endif

// File: pkg/facd_pkg.sv
package facd_pkg;
   typedef enum logic [2:0]
   {
      FACD_IDLE = 3'b000,
      FACD_PRE  = 3'b001,
      FACD_EXEC = 3'b011,
      FACD_ACK  = 3'b010
   } facd_state_e;

   typedef enum logic [3:0]
   {
      FACD_K_NONE, FACD_K_LOCK, FACD_K_TSW, FACD_K_RSC, FACD_K_RST,
      FACD_K_WST, FACD_K_REXC, FACD_K_RREG, FACD_K_WREG, FACD_K_MUL,
      FACD_K_NEG, FACD_K_SUB, FACD_K_FLOOR, FACD_K_ROUND, FACD_K_TRUNC
   } facd_kind_e;

   typedef struct packed
   {
      facd_kind_e  kind;
      logic        long_fmt;
      logic        imm_src;
      logic        imm_dst;
      logic        priv;
      logic        illegal;
      logic [5:0]  src;
      logic [5:0]  dst;
   } facd_dec_s;
endpackage

// File: verilog/facd_decode.sv
`timescale 1ns/1ps
`include "facd_cfg.svh"
module facd_decode
(
   // Command address bits 12-31
   input  wire logic [19:0]         cmd,
   // Decoded command
   output facd_pkg::facd_dec_s      dec
);
   logic [3:0] pre;
   logic [3:0] op;
   logic [1:0] fmt;
   assign pre = cmd[19:16];
   assign op  = cmd[15:12];
   assign fmt = cmd[11:10];

   always_comb
   begin
      dec = '0;
      dec.kind = facd_pkg::FACD_K_NONE;
      dec.src  = cmd[9:4];
      dec.dst  = cmd[5:0];
      dec.imm_src = (pre == `FACD_PRE_IMM_SRC)
                    || (pre == `FACD_PRE_IMM_CSRC);
      dec.imm_dst = (pre == `FACD_PRE_IMM_DST);
      if (pre == `FACD_PRE_PRIV && op == `FACD_OP_LOCK
          && cmd[11:0] == 12'h000)
      begin
         dec.kind = facd_pkg::FACD_K_LOCK;
         dec.priv = 1'b1;
      end
      else if (pre == `FACD_PRE_PRIV && op == `FACD_OP_TSW
               && cmd[11:5] == 7'(`FACD_TAIL_STAT >> 5))
      begin
         dec.kind = facd_pkg::FACD_K_TSW;
         dec.priv = 1'b1;
         dec.src  = {2'b00, `FACD_REG_STAT};
      end
      else if (op == `FACD_OP_STAT && cmd[11:0] == `FACD_TAIL_STAT
               && (pre == `FACD_PRE_PRIV || pre == `FACD_PRE_CONV))
      begin
         dec.priv = (pre == `FACD_PRE_PRIV);
         dec.kind = dec.priv ? facd_pkg::FACD_K_RSC
                             : facd_pkg::FACD_K_RST;
      end
      else if (pre == `FACD_PRE_WSTAT && op == `FACD_OP_TSW
               && cmd[11:0] == `FACD_TAIL_STAT)
         dec.kind = facd_pkg::FACD_K_WST;
      else if (pre == `FACD_PRE_PRIV && op == `FACD_OP_RDREG)
      begin
         if (cmd[11:0] == `FACD_TAIL_EXC)
            dec.kind = facd_pkg::FACD_K_REXC;
         else
         begin
            dec.kind = facd_pkg::FACD_K_RREG;
            dec.src  = {2'b00, cmd[9:6]};
            dec.illegal = (cmd[9:6] > 4'hD);
         end
      end
      else if (pre == `FACD_PRE_PRIV && op == `FACD_OP_WRREG)
      begin
         dec.kind = facd_pkg::FACD_K_WREG;
         dec.dst  = cmd[7:2];
         dec.illegal = (cmd[7:2] > 6'h0D);
      end
      else if (pre == `FACD_PRE_PLAIN || pre == `FACD_PRE_IMM_SRC
               || pre == `FACD_PRE_IMM_DST || pre == `FACD_PRE_CONV
               || pre == `FACD_PRE_IMM_CSRC)
      begin
         dec.long_fmt = (fmt == 2'b00) || op == `FACD_OP_FLOOR
                        || op == `FACD_OP_TRUNC_L;
         unique case (op)
            `FACD_OP_MUL:     dec.kind = facd_pkg::FACD_K_MUL;
            `FACD_OP_NEG:     dec.kind = facd_pkg::FACD_K_NEG;
            // Round shares its opcode with subtract and is told apart by
            // format code 11; floor and truncate have opcodes of their own.
            `FACD_OP_SUB:     dec.kind = (fmt == 2'b11)
                                 ? facd_pkg::FACD_K_ROUND
                                 : facd_pkg::FACD_K_SUB;
            `FACD_OP_FLOOR:   dec.kind = facd_pkg::FACD_K_FLOOR;
            `FACD_OP_TRUNC_S,
            `FACD_OP_TRUNC_L: dec.kind = facd_pkg::FACD_K_TRUNC;
            default:          dec.illegal = 1'b1;
         endcase
         // Long operands start at the even register of a pair.
         dec.src = {2'b00, cmd[9:7], cmd[6] && !dec.long_fmt};
         dec.dst = {2'b00, cmd[5:3], cmd[2] && fmt != 2'b00};
      end
      else
         dec.illegal = 1'b1;
   end
endmodule

// File: verilog/facd_core.sv
`timescale 1ns/1ps
`include "facd_cfg.svh"
module facd_core
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Supervisor state pin
   input  wire logic        supervisor_in,
   // Unit state
   output logic             locked,
   output logic             exc_pulse,
   output logic      [4:0]  task_id
);
   // -----------------------------------------------------------------
   // Pin synchroniser
   // -----------------------------------------------------------------
   logic sup_s1;
   logic sup_s2;
   always_ff @(posedge ref_clk)
   begin
      sup_s1 <= supervisor_in;
      sup_s2 <= sup_s1;
   end

   // -----------------------------------------------------------------
   // Operand store, one bank of 64 registers for each of 32 tasks
   // -----------------------------------------------------------------
   logic [31:0] regs [0:2047];
   logic [31:0] hw_stat;
   logic [31:0] next_hw_stat;
   logic [31:0] exc_reg;
   logic [31:0] next_exc_reg;
   logic [4:0]  next_task_id;
   logic        next_locked;
   logic [19:0] cmd;
   logic [19:0] next_cmd;
   logic [31:0] data;
   logic [31:0] next_data;
   logic [31:0] result;
   logic [31:0] next_result;
   logic [31:0] src_v;
   logic [31:0] dst_v;
   logic        next_ack;
   logic [31:0] next_dat_o;
   logic        next_exc_pulse;
   facd_pkg::facd_state_e state;
   facd_pkg::facd_state_e next_state;
   facd_pkg::facd_dec_s   dec;
   logic        wr_en;
   logic [10:0] wr_adr;
   logic [31:0] wr_val;
   logic [31:0] src_op;
   logic [31:0] dst_op;
   logic [4:0]  rd_task;

   facd_decode u_dec
   (
      .cmd (cmd),
      .dec (dec)
   );

   function automatic logic [10:0] rix(input logic [4:0] t,
                                       input logic [5:0] r);
      rix = {t, r};
   endfunction

   // A task switch reads the status word of the task it enters.
   assign rd_task = (dec.kind == facd_pkg::FACD_K_TSW)
                    ? cmd[4:0] : task_id;
   // Immediate data lands in the edge that reads the operand, so the
   // execute stage takes it straight from the data register.
   assign src_op = dec.imm_src ? data : src_v;
   assign dst_op = dec.imm_dst ? data : dst_v;

   always_ff @(posedge ref_clk)
   begin
      src_v <= regs[rix(rd_task, dec.src)];
      dst_v <= regs[rix(task_id, dec.dst)];
      if (wr_en)
         regs[wr_adr] <= wr_val;
   end

   // -----------------------------------------------------------------
   // Bus and command sequencing
   // -----------------------------------------------------------------
   logic req;
   logic bad;
   logic [31:0] imm_val;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign imm_val = data;
   always_comb
   begin
      next_state = state;
      next_ack = 1'b0;
      next_dat_o = wb_dat_o;
      next_cmd = cmd;
      next_data = data;
      next_result = result;
      next_hw_stat = hw_stat;
      next_exc_reg = exc_reg;
      next_task_id = task_id;
      next_locked = locked;
      next_exc_pulse = 1'b0;
      wr_en = 1'b0;
      wr_adr = '0;
      wr_val = '0;
      bad = 1'b0;
      unique case (state)
         facd_pkg::FACD_IDLE:
            if (req)
            begin
               if (wb_we_i && wb_adr_i == `FACD_ADR_DATA)
               begin
                  next_data = wb_dat_i;
                  next_ack = 1'b1;
               end
               else if (wb_we_i && wb_adr_i == `FACD_ADR_CMD)
               begin
                  next_cmd = wb_dat_i[19:0];
                  next_state = facd_pkg::FACD_PRE;
               end
               else
               begin
                  unique case (wb_adr_i)
                     `FACD_ADR_STAT:   next_dat_o = {27'h0, locked, exc_reg[3:0]};
                     `FACD_ADR_RESULT: next_dat_o = result;
                     `FACD_ADR_HWSTAT: next_dat_o = hw_stat;
                     `FACD_ADR_CMD:    next_dat_o = {12'h0, cmd};
                     default:          next_dat_o = 32'h0000_0000;
                  endcase
                  next_ack = 1'b1;
               end
            end
         facd_pkg::FACD_PRE:
         begin
            bad = dec.illegal || dec.kind == facd_pkg::FACD_K_NONE;
            if (locked && dec.kind != facd_pkg::FACD_K_LOCK
                && dec.kind != facd_pkg::FACD_K_TSW
                && dec.kind != facd_pkg::FACD_K_RSC)
               bad = 1'b1;
            if (bad)
            begin
               next_exc_reg = {28'h0, `FACD_EXC_ILLEGAL};
               next_exc_pulse = 1'b1;
               next_state = facd_pkg::FACD_ACK;
            end
            else if (dec.priv && !sup_s2)
            begin
               next_exc_reg = {28'h0, `FACD_EXC_PRIV};
               next_exc_pulse = 1'b1;
               next_state = facd_pkg::FACD_ACK;
            end
            else
            begin
               if (dec.imm_src)
               begin
                  wr_en = 1'b1;
                  wr_adr = rix(task_id, dec.src);
                  wr_val = imm_val;
               end
               else if (dec.imm_dst)
               begin
                  wr_en = 1'b1;
                  wr_adr = rix(task_id, dec.dst);
                  wr_val = imm_val;
               end
               next_state = facd_pkg::FACD_EXEC;
            end
         end
         facd_pkg::FACD_EXEC:
         begin
            next_state = facd_pkg::FACD_ACK;
            wr_adr = rix(task_id, dec.dst);
            unique case (dec.kind)
               facd_pkg::FACD_K_LOCK: next_locked = 1'b1;
               facd_pkg::FACD_K_TSW:
               begin
                  next_task_id = cmd[4:0];
                  next_locked = 1'b0;
                  // Unwritable bits stay hardware owned, as on a write.
                  next_hw_stat = (hw_stat & `FACD_STAT_RO_MASK)
                                 | (src_v & ~`FACD_STAT_RO_MASK);
               end
               facd_pkg::FACD_K_RSC, facd_pkg::FACD_K_RST:
               begin
                  wr_en = 1'b1;
                  wr_adr = rix(task_id, {2'b00, `FACD_REG_STAT});
                  wr_val = hw_stat;
                  next_result = hw_stat;
                  if (dec.kind == facd_pkg::FACD_K_RSC)
                  begin
                     next_hw_stat = hw_stat & ~`FACD_CHECK_MASK;
                     next_exc_reg = '0;
                  end
               end
               facd_pkg::FACD_K_WST:
               begin
                  wr_en = 1'b1;
                  wr_adr = rix(task_id, {2'b00, `FACD_REG_STAT});
                  wr_val = data;
                  next_hw_stat = (hw_stat & `FACD_STAT_RO_MASK)
                                 | (data & ~`FACD_STAT_RO_MASK);
               end
               facd_pkg::FACD_K_REXC: next_result = exc_reg;
               facd_pkg::FACD_K_RREG: next_result = src_v;
               facd_pkg::FACD_K_WREG:
               begin
                  wr_en = 1'b1;
                  wr_val = data;
               end
               facd_pkg::FACD_K_MUL:
               begin
                  wr_en = 1'b1;
                  wr_val = 32'(src_op * dst_op);
               end
               facd_pkg::FACD_K_NEG:
               begin
                  wr_en = 1'b1;
                  wr_val = -src_op;
               end
               facd_pkg::FACD_K_SUB:
               begin
                  wr_en = 1'b1;
                  wr_val = dst_op - src_op;
               end
               facd_pkg::FACD_K_FLOOR, facd_pkg::FACD_K_ROUND,
               facd_pkg::FACD_K_TRUNC:
               begin
                  wr_en = 1'b1;
                  wr_val = src_op;
               end
               default: wr_en = 1'b0;
            endcase
         end
         facd_pkg::FACD_ACK:
         begin
            next_ack = 1'b1;
            next_dat_o = result;
            next_state = facd_pkg::FACD_IDLE;
         end
         default: next_state = facd_pkg::FACD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state <= facd_pkg::FACD_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         cmd <= '0;
         data <= '0;
         result <= '0;
         hw_stat <= '0;
         exc_reg <= '0;
         task_id <= '0;
         locked <= 1'b1;
         exc_pulse <= 1'b0;
      end
      else
      begin
         state <= next_state;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat_o;
         cmd <= next_cmd;
         data <= next_data;
         result <= next_result;
         hw_stat <= next_hw_stat;
         exc_reg <= next_exc_reg;
         task_id <= next_task_id;
         locked <= next_locked;
         exc_pulse <= next_exc_pulse;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_lock_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_EXEC && dec.kind == facd_pkg::FACD_K_LOCK
      |=> locked) else $error("lock not taken");
   a_task_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_EXEC && dec.kind == facd_pkg::FACD_K_TSW
      |=> !locked && task_id == $past(cmd[4:0])) else $error("task");
   a_locked_trap: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_PRE && locked
      && dec.kind == facd_pkg::FACD_K_MUL
      |=> exc_pulse && exc_reg[3:0] == 4'h7) else $error("trap");
   a_priv_trap: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_PRE && !dec.illegal && dec.priv && !sup_s2
      |=> exc_pulse) else $error("priv");
   a_ack_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
   a_cmd_ack: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_PRE |-> ##[2:3] wb_ack_o)
      else $error("no ack");
   a_wst_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_EXEC && dec.kind == facd_pkg::FACD_K_WST
      |=> hw_stat[31:24] == $past(hw_stat[31:24])) else $error("ro");
   a_rsc_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state == facd_pkg::FACD_EXEC && dec.kind == facd_pkg::FACD_K_RSC
      |=> exc_reg == 32'h0000_0000) else $error("clear");
   c_lock: cover property (@(posedge ref_clk) locked ##1 !locked);
   c_trap: cover property (@(posedge ref_clk) exc_pulse);
   c_mul: cover property (@(posedge ref_clk)
      state == facd_pkg::FACD_EXEC && dec.kind == facd_pkg::FACD_K_MUL);
endmodule

// File: sim/facd_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host model: classic Wishbone master issuing loads and stores
// ----------------------------------------------------------------
module facd_host
(
   // Clock
   input  wire logic        ref_clk,
   // Wishbone master
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic      [7:0]  wb_adr_o,
   output logic      [3:0]  wb_sel_o,
   output logic      [31:0] wb_dat_o,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i,
   // Wait limit ran out
   output logic             timeout
);
   initial
   begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'hF;
      wb_dat_o = 32'h0000_0000;
      timeout  = 1'b0;
   end

   // One cycle; data lines show the inverse once released, so a
   // design that samples late cannot see a stale value by luck.
   task xfer(input logic we, input logic [7:0] adr,
             input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge ref_clk);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_sel_o <= 4'hF;
      wb_adr_o <= adr;
      wb_dat_o <= wd;
      for (n = 0; n < 64; n++)
      begin
         @(posedge ref_clk);
         if (wb_ack_i === 1'b1)
            break;
      end
      if (n == 64)
         timeout = 1'b1;
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~wd;
   endtask

   // Operand first, then the command field of address bits 12-31.
   task command(input logic [19:0] c, input logic [31:0] d);
      logic [31:0] unused;
      xfer(1'b1, 8'h04, d, unused);
      xfer(1'b1, 8'h00, {12'h000, c}, unused);
   endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic        ref_clk;
   logic        reset_n;
   logic        supervisor_in;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        locked;
   logic        exc_pulse;
   logic [4:0]  task_id;
   logic        timeout;
   logic [31:0] v;
   int          n_fail;
   int          tests_run;
   int          n_exc;
   int          n0;

   facd_core i_facd_core
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .supervisor_in(supervisor_in),
      .locked(locked), .exc_pulse(exc_pulse), .task_id(task_id)
   );

   facd_host i_facd_host
   (
      .ref_clk(ref_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
      .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
      .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack),
      .timeout(timeout)
   );

   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
      if (exc_pulse === 1'b1)
         n_exc <= n_exc + 1;

   task finish_test;
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   // A hung bus ends the run as a mismatch.
   task guard;
      if (timeout === 1'b1)
      begin
         n_fail++;
         finish_test;
      end
   endtask

   task cmd(input logic [19:0] c, input logic [31:0] d);
      i_facd_host.command(c, d);
      guard;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] r);
      i_facd_host.xfer(1'b0, a, 32'h0000_0000, r);
      guard;
   endtask

   task reg_rd(input logic [3:0] r, output logic [31:0] q);
      cmd({8'h2F, 2'b00, r, 6'h00}, 32'h0000_0000);
      rd(8'h0C, q);
   endtask

   task refuse(input logic [19:0] c, input logic [3:0] code);
      n0 = n_exc;
      cmd(c, 32'h0000_0001);
      rd(8'h08, v);
      check("exc_count", 32'(n0 + 1), 32'(n_exc));
      check("exc_code", 32'(code), 32'(v[3:0]));
   endtask

   function automatic logic [19:0] sh(logic [3:0] p, logic [3:0] o,
                                      logic [3:0] a, logic [3:0] b);
      return {p, o, 2'b01, a, b, 2'b00};
   endfunction

   function automatic logic [19:0] lg(logic [3:0] p, logic [3:0] o,
                                      logic [3:0] a, logic [3:0] b);
      return {p, o, 2'b00, a, b[3:1], 3'b000};
   endfunction

   initial
   begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      supervisor_in = 1'b1;
      n_fail = 0;
      tests_run = 0;
      n_exc = 0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      check("locked", 32'h0000_0001, 32'(locked));
      check("task_id", 32'h0000_0000, 32'(task_id));
      refuse(sh(4'h1, 4'hC, 4'd2, 4'd3), 4'h7);
      cmd(20'h2_3FB8, 32'h0000_0000);
      check("locked", 32'h0000_0000, 32'(locked));
      check("task_id", 32'h0000_0018, 32'(task_id));
      supervisor_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      refuse(20'h2_7000, 4'h8);
      supervisor_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
         cmd({8'h25, 6'h00, 4'(i), 2'b00}, 32'(i + 1));
      for (int i = 0; i < 8; i++)
      begin
         reg_rd(4'(i), v);
         check("reg_rd", 32'(i + 1), v);
      end
      cmd(sh(4'h1, 4'hC, 4'd2, 4'd3), 32'h0000_0000);
      reg_rd(4'd3, v);
      check("product", 32'h0000_000C, v);
      cmd(sh(4'h1, 4'h4, 4'd2, 4'd3), 32'h0000_0000);
      reg_rd(4'd3, v);
      check("difference", 32'h0000_0009, v);
      cmd(sh(4'h1, 4'h5, 4'd2, 4'd4), 32'h0000_0000);
      reg_rd(4'd4, v);
      check("sign_flip", 32'hFFFF_FFFD, v);
      cmd(sh(4'h9, 4'hC, 4'd2, 4'd3), 32'h0000_0007);
      reg_rd(4'd2, v);
      check("imm_src", 32'h0000_0007, v);
      reg_rd(4'd3, v);
      check("imm_product", 32'h0000_003F, v);
      cmd(sh(4'h5, 4'h4, 4'd2, 4'd3), 32'h0000_0064);
      reg_rd(4'd3, v);
      check("imm_dst", 32'h0000_005D, v);
      // Odd source number: the pair must still start at register 4.
      cmd(lg(4'h9, 4'h5, 4'd5, 4'd0), 32'h1234_5678);
      reg_rd(4'd4, v);
      check("long_high", 32'h1234_5678, v);
      reg_rd(4'd5, v);
      check("long_low", 32'h0000_0006, v);
      cmd({8'h0B, 2'b11, 4'd2, 4'd5, 2'b00}, 32'h0000_0000);
      reg_rd(4'd2, v);
      check("trunc_src", 32'h0000_0007, v);
      reg_rd(4'd5, v);
      check("trunc_dst", 32'h0000_0007, v);
      cmd({8'h04, 2'b11, 4'd3, 4'd9, 2'b00}, 32'h0000_0000);
      reg_rd(4'd9, v);
      check("round_dst", 32'h0000_005D, v);
      for (int k = 0; k < 2; k++)
      begin
         cmd({4'h0, k ? 4'hA : 4'hE, 6'b11_0110, 4'd8, 2'b00},
             32'h0000_0000);
         reg_rd(4'd6, v);
         check("long_src", 32'h0000_0007, v);
         reg_rd(4'd8, v);
         check("long_dst", 32'h0000_0007, v);
      end
      cmd(20'h4_3FB8, 32'h00AA_55AA);
      cmd(20'h0_DFB8, 32'h0000_0000);
      rd(8'h0C, v);
      check("status", 32'h00AA_55AA, {8'h00, v[23:0]});
      cmd(20'h2_DFB8, 32'h0000_0000);
      rd(8'h0C, v);
      check("status_clr", 32'h00AA_55AA, {8'h00, v[23:0]});
      cmd(20'h0_DFB8, 32'h0000_0000);
      rd(8'h0C, v);
      check("checks", 32'h0000_0000, 32'(v[7:0]));
      n0 = n_exc;
      cmd(20'h2_F3C0, 32'h0000_0000);
      check("exc_read", 32'(n0), 32'(n_exc));
      rd(8'h20, v);
      check("unmapped", 32'h0000_0000, v);
      refuse(20'hF_0000, 4'h7);
      cmd(20'h2_F3C0, 32'h0000_0000);
      rd(8'h0C, v);
      check("exc_value", 32'h0000_0007, v);
      cmd(20'h2_7000, 32'h0000_0000);
      check("locked", 32'h0000_0001, 32'(locked));
      n0 = n_exc;
      cmd(20'h2_DFB8, 32'h0000_0000);
      check("locked_ok", 32'(n0), 32'(n_exc));
      finish_test;
   end
endmodule
